// File: tap_decode_map.vh
`ifndef TAP_DECODE_MAP_VH
`define TAP_DECODE_MAP_VH
`define IR_WIDTH            5
`define IR_CAPTURE          5'h01
`define INS_IDENT           5'h01
`define INS_IMPL            5'h03
`define INS_ADDR            5'h08
`define INS_DATA            5'h09
`define INS_CTRL            5'h0A
`define INS_ALL             5'h0B
`define INS_DBOOT           5'h0C
`define INS_NBOOT           5'h0D
`define INS_FAST            5'h0E
`define INS_BYPASS          5'h1F
`define ID_VER_MSB          31
`define ID_VER_LSB          28
`define ID_PART_MSB         27
`define ID_PART_LSB         12
`define ID_MAKER_MSB        11
`define ID_MAKER_LSB        1
`define ID_FIXED_BIT        1'h1
`define PATH_ID             3'h0
`define PATH_IMPL           3'h1
`define PATH_ADDR           3'h2
`define PATH_DATA           3'h3
`define PATH_CTRL           3'h4
`define PATH_ALL            3'h5
`define PATH_FAST           3'h6
`define PATH_BYPASS         3'h7
`endif

// File: scan_fifo.v
`timescale 1ns/1ps
// =====================================================================
// Small word FIFO; read data come out of a register.
module scan_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             i_clk,    // clock
  input  wire             i_rst_b,  // async reset, active low
  input  wire             i_valid,  // write request
  output wire             o_ready,  // not full
  input  wire [WIDTH-1:0] i_data,   // write data
  output reg              o_valid,  // read data valid
  input  wire             i_ready,  // read accept
  output reg  [WIDTH-1:0] o_data    // read data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ff;
  reg [AW:0]      rd_ff;
  wire            full;
  wire            empty;
  wire            pop;

  assign full    = (wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
  assign empty   = (wr_ff == rd_ff);
  assign o_ready = ~full;
  // The output register refills whenever a word is stored and it is empty or being drained.
  assign pop     = ~empty && (~o_valid || i_ready);

  always @(posedge i_clk) begin
    if (i_valid && ~full) begin
      mem[wr_ff[AW-1:0]] <= i_data;
    end
  end

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_ff   <= {(AW+1){1'b0}};
      rd_ff   <= {(AW+1){1'b0}};
      o_valid <= 1'b0;
      o_data  <= {WIDTH{1'b0}};
    end else begin
      if (i_valid && ~full) begin
        wr_ff <= wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff   <= rd_ff + 1'b1;
        o_data  <= mem[rd_ff[AW-1:0]];
        o_valid <= 1'b1;
      end else if (i_ready) begin
        o_valid <= 1'b0;
      end
    end
  end
endmodule // scan_fifo

// File: tap_decode.v
`timescale 1ns/1ps
`include "tap_decode_map.vh"
module tap_decode #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW    = 4
) (
  input  wire        I_CLK,          // 100 MHz system clock
  input  wire        I_RST_B,        // async reset, active low
  input  wire        I_TCK,          // probe scan clock
  input  wire        I_TDI,          // probe serial in
  input  wire        I_TRST_B,       // optional port reset, active low
  input  wire        I_TLR,          // controller in Test-Logic-Reset
  input  wire        I_CAPTURE_IR,   // controller in capture-IR
  input  wire        I_SHIFT_IR,     // controller in shift-IR
  input  wire        I_UPDATE_IR,    // controller in update-IR
  input  wire        I_CAPTURE_DR,   // controller in capture-DR
  input  wire        I_SHIFT_DR,     // controller in shift-DR
  input  wire        I_UPDATE_DR,    // controller in update-DR
  input  wire        I_CPU_RESET,    // hard or soft processor reset, level
  input  wire [3:0]  I_VERSION,      // core_version_input
  input  wire [15:0] I_PART,         // core_part_input
  input  wire [10:0] I_MAKER,        // core_maker_input
  input  wire [31:0] I_IMPL,         // implementation register value
  input  wire [31:0] I_ADDR_CAP,     // address value to capture
  input  wire [31:0] I_DATA_CAP,     // data value to capture
  input  wire [31:0] I_CTRL_CAP,     // debug_control_register current bits
  input  wire        I_FAST_CAP,     // fast-data bit to capture
  input  wire        I_UPD_READY,    // consumer accepts update words
  output reg         O_TDO,          // probe serial out
  output reg  [4:0]  O_INSTR,        // current instruction
  output reg         O_BOOT_DEBUG,   // preset value for the three boot bits
  output reg         O_PRESET_STB,   // pulse: apply preset to control bits
  output reg         O_UPD_VALID,    // update word valid
  output reg  [2:0]  O_UPD_PATH,     // path of update word
  output reg  [31:0] O_UPD_WORD,     // update word
  output reg         O_UPD_EXTRA,    // second-register bit of update
  output reg         O_UPD_OVF       // update dropped, FIFO full
);
  // ===================================================================
  // Pin synchronisers.
  reg  [2:0] tck_ff;
  reg  [1:0] tdi_ff;
  reg  [1:0] trst_ff;
  reg  [1:0] cpu_ff;
  wire [6:0] st_in;
  wire [6:0] st;
  wire       tck_rise;
  wire       tck_fall;
  wire       tdi;
  wire       trst_b;
  wire       cpu_rst;

  assign st_in = {I_TLR, I_CAPTURE_IR, I_SHIFT_IR, I_UPDATE_IR, I_CAPTURE_DR, I_SHIFT_DR, I_UPDATE_DR};

  genvar g;
  generate
    for (g = 0; g < 7; g = g + 1) begin : g_sync
      // Each state level owns its own pair of flops, so no vector has two drivers.
      reg [1:0] sync_ff;
      always @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
          sync_ff <= 2'h0;
        end else begin
          sync_ff <= {sync_ff[0], st_in[g]};
        end
      end
      assign st[g] = sync_ff[1];
    end
  endgenerate

  always @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      tck_ff  <= 3'h0;
      tdi_ff  <= 2'h0;
      trst_ff <= 2'h0;
      cpu_ff  <= 2'h0;
    end else begin
      tck_ff  <= {tck_ff[1:0], I_TCK};
      tdi_ff  <= {tdi_ff[0], I_TDI};
      trst_ff <= {trst_ff[0], I_TRST_B};
      cpu_ff  <= {cpu_ff[0], I_CPU_RESET};
    end
  end

  assign tck_rise = tck_ff[1] & ~tck_ff[2];
  assign tck_fall = ~tck_ff[1] & tck_ff[2];
  assign tdi      = tdi_ff[1];
  assign trst_b   = trst_ff[1];
  assign cpu_rst  = cpu_ff[1];

  wire tlr  = st[6];
  wire cir  = st[5];
  wire sir  = st[4];
  wire uir  = st[3];
  wire cdr  = st[2];
  wire sdr  = st[1];
  wire udr  = st[0];

  // ===================================================================
  // Instruction register and decode.
  reg  [4:0]  ir_sh_ff;
  reg  [4:0]  ir_ff;
  reg  [2:0]  path;
  reg         uir_seen_ff;
  reg         boot_pend_ff;
  reg         boot_val_ff;

  always @* begin
    case (ir_ff)
      `INS_IDENT: path = `PATH_ID;
      `INS_IMPL:  path = `PATH_IMPL;
      `INS_ADDR:  path = `PATH_ADDR;
      `INS_DATA:  path = `PATH_DATA;
      `INS_CTRL:  path = `PATH_CTRL;
      `INS_ALL:   path = `PATH_ALL;
      `INS_FAST:  path = `PATH_FAST;
      default:    path = `PATH_BYPASS;
    endcase
  end

  always @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ir_sh_ff     <= `IR_CAPTURE;
      ir_ff        <= `INS_IDENT;
      uir_seen_ff  <= 1'b0;
      boot_val_ff  <= 1'b0;
    end else if (!trst_b) begin
      ir_sh_ff     <= `IR_CAPTURE;
      ir_ff        <= `INS_IDENT;
      uir_seen_ff  <= 1'b0;
      boot_val_ff  <= 1'b0;
    end else if (tck_rise) begin
      uir_seen_ff <= uir;
      if (tlr) begin
        ir_sh_ff    <= `IR_CAPTURE;
        ir_ff       <= `INS_IDENT;
        boot_val_ff <= 1'b0;
      end else if (cir) begin
        ir_sh_ff <= `IR_CAPTURE;
      end else if (sir) begin
        ir_sh_ff <= {tdi, ir_sh_ff[4:1]};
      end
      if (uir && !tlr) begin
        ir_ff <= ir_sh_ff;
      end
      // The boot choice takes effect as update-IR is left.
      if (uir_seen_ff && !uir && !tlr) begin
        if (ir_ff == `INS_DBOOT) begin
          boot_val_ff <= 1'b1;
        end else if (ir_ff == `INS_NBOOT) begin
          boot_val_ff <= 1'b0;
        end
      end
    end
  end

  // ===================================================================
  // Data shift paths; only the selected path moves.
  reg [31:0] id_sh_ff;
  reg [31:0] gen_sh_ff;
  reg [95:0] all_sh_ff;
  reg [32:0] fast_sh_ff;
  reg        byp_ff;
  reg        dr_out;
  reg        tdo_src;

  always @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      id_sh_ff   <= 32'h0;
      gen_sh_ff  <= 32'h0;
      all_sh_ff  <= 96'h0;
      fast_sh_ff <= 33'h0;
      byp_ff     <= 1'b0;
    end else if (tck_rise && cdr) begin
      case (path)
        `PATH_ID:   id_sh_ff <= {I_VERSION, I_PART, I_MAKER, `ID_FIXED_BIT};
        `PATH_IMPL: gen_sh_ff <= I_IMPL;
        `PATH_ADDR: gen_sh_ff <= I_ADDR_CAP;
        `PATH_DATA: gen_sh_ff <= I_DATA_CAP;
        `PATH_CTRL: gen_sh_ff <= I_CTRL_CAP;
        `PATH_ALL:  all_sh_ff <= {I_CTRL_CAP, I_DATA_CAP, I_ADDR_CAP};
        `PATH_FAST: fast_sh_ff <= {I_DATA_CAP, I_FAST_CAP};
        default:    byp_ff <= 1'b0;
      endcase
    end else if (tck_rise && sdr) begin
      case (path)
        `PATH_ID:   id_sh_ff <= {tdi, id_sh_ff[31:1]};
        `PATH_IMPL: gen_sh_ff <= {tdi, gen_sh_ff[31:1]};
        `PATH_ADDR, `PATH_DATA, `PATH_CTRL: gen_sh_ff <= {tdi, gen_sh_ff[31:1]};
        `PATH_ALL:  all_sh_ff <= {tdi, all_sh_ff[95:1]};
        `PATH_FAST: fast_sh_ff <= {tdi, fast_sh_ff[32:1]};
        default:    byp_ff <= tdi;
      endcase
    end
  end

  always @* begin
    case (path)
      `PATH_ID:   dr_out = id_sh_ff[0];
      `PATH_ALL:  dr_out = all_sh_ff[0];
      `PATH_FAST: dr_out = fast_sh_ff[0];
      `PATH_BYPASS: dr_out = byp_ff;
      default:    dr_out = gen_sh_ff[0];
    endcase
    tdo_src = sir ? ir_sh_ff[0] : dr_out;
  end

  // ===================================================================
  // Update words queue toward the control logic of the core.
  reg         upd_req;
  reg  [31:0] upd_word;
  reg         upd_extra;
  wire        fifo_ready;
  wire        fifo_valid;
  wire [35:0] fifo_data;
  wire        out_ready;

  // The output stage is a register slice: it takes a word only when empty or being drained.
  assign out_ready = !O_UPD_VALID || I_UPD_READY;

  always @* begin
    upd_req   = tck_rise && udr && (path == `PATH_ADDR || path == `PATH_DATA || path == `PATH_CTRL ||
                path == `PATH_ALL || path == `PATH_FAST);
    upd_word  = gen_sh_ff;
    upd_extra = 1'b0;
    if (path == `PATH_FAST) begin
      upd_word  = fast_sh_ff[32:1];
      upd_extra = fast_sh_ff[0];
    end else if (path == `PATH_ALL) begin
      upd_word  = all_sh_ff[95:64];
    end
  end

  scan_fifo #(
    .WIDTH (36),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .i_clk   (I_CLK),
    .i_rst_b (I_RST_B),
    .i_valid (upd_req),
    .o_ready (fifo_ready),
    .i_data  ({path, upd_extra, upd_word}),
    .o_valid (fifo_valid),
    .i_ready (out_ready),
    .o_data  (fifo_data)
  );

  // ===================================================================
  // Output registers.
  always @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_TDO        <= 1'b0;
      O_INSTR      <= `INS_IDENT;
      O_BOOT_DEBUG <= 1'b0;
      O_PRESET_STB <= 1'b0;
      O_UPD_VALID  <= 1'b0;
      O_UPD_PATH   <= 3'h0;
      O_UPD_WORD   <= 32'h0;
      O_UPD_EXTRA  <= 1'b0;
      O_UPD_OVF    <= 1'b0;
      boot_pend_ff <= 1'b0;
    end else begin
      if (tck_fall) begin
        O_TDO <= tdo_src;
      end
      O_INSTR      <= ir_ff;
      O_BOOT_DEBUG <= boot_val_ff;
      // One preset pulse per processor reset; the TAP reset does not preset.
      O_PRESET_STB <= cpu_rst && !boot_pend_ff;
      boot_pend_ff <= cpu_rst;
      if (fifo_valid && out_ready) begin
        O_UPD_VALID <= 1'b1;
        O_UPD_PATH  <= fifo_data[35:33];
        O_UPD_EXTRA <= fifo_data[32];
        O_UPD_WORD  <= fifo_data[31:0];
      end else if (I_UPD_READY) begin
        O_UPD_VALID <= 1'b0;
      end
      O_UPD_OVF    <= upd_req && !fifo_ready;
    end
  end
endmodule // tap_decode

// File: tap_decode_sva.sv
`timescale 1ns/1ps
// ====
// Port checks for the instruction decode, TDO timing, preset pulse and update stream.
module tap_decode_sva #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW    = 4
) (
  input wire        I_CLK,        // clock
  input wire        I_RST_B,      // reset, low
  input wire        I_TCK,        // scan clock
  input wire        I_TRST_B,     // port reset, low
  input wire        I_TLR,        // reset state
  input wire        I_UPDATE_IR,  // update-IR
  input wire        I_CPU_RESET,  // cpu reset
  input wire        I_UPD_READY,  // stream ready
  input wire        O_TDO,        // serial out
  input wire [4:0]  O_INSTR,      // instruction
  input wire        O_BOOT_DEBUG, // boot flag
  input wire        O_PRESET_STB, // preset pulse
  input wire        O_UPD_VALID,  // stream valid
  input wire [31:0] O_UPD_WORD    // stream word
);
  reg [3:0] fall_ago_ff;
  reg [3:0] ir_ago_ff;
  reg [3:0] cpu_ago_ff;
  // Counters saturate, so an old cause never excuses a late change.
  always @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      fall_ago_ff <= 4'hF;
      ir_ago_ff   <= 4'hF;
      cpu_ago_ff  <= 4'hF;
    end else begin
      fall_ago_ff <= $fell(I_TCK) ? 4'h0 : fall_ago_ff + {3'h0, fall_ago_ff != 4'hF};
      ir_ago_ff   <= (I_UPDATE_IR || I_TLR || !I_TRST_B) ? 4'h0 : ir_ago_ff + {3'h0, ir_ago_ff != 4'hF};
      cpu_ago_ff  <= $rose(I_CPU_RESET) ? 4'h0 : cpu_ago_ff + {3'h0, cpu_ago_ff != 4'hF};
    end
  end
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_B);
  sequence s_tlr_step; I_TLR && $rose(I_TCK); endsequence
  sequence s_ident_clear; O_INSTR == 5'h01 && !O_BOOT_DEBUG; endsequence
  property p_rst_ident; $rose(I_RST_B) |-> s_ident_clear; endproperty
  a_rst_ident: assert property (p_rst_ident) else $error("not ident after reset");
  property p_tlr_ident; s_tlr_step |-> ##[2:8] s_ident_clear; endproperty
  a_tlr_ident: assert property (p_tlr_ident) else $error("not ident after TLR");
  property p_trst_clear; $fell(I_TRST_B) |-> ##[2:8] s_ident_clear; endproperty
  a_trst_clear: assert property (p_trst_clear) else $error("port reset ignored");
  property p_tdo_fall; $changed(O_TDO) |-> fall_ago_ff <= 4'h6; endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("TDO moved off a fall");
  property p_instr_hold; $changed(O_INSTR) |-> ir_ago_ff <= 4'hE; endproperty
  a_instr_hold: assert property (p_instr_hold) else $error("instruction moved");
  property p_boot_hold; $changed(O_BOOT_DEBUG) |-> ir_ago_ff <= 4'hE; endproperty
  a_boot_hold: assert property (p_boot_hold) else $error("boot flag moved");
  property p_preset; O_PRESET_STB |-> cpu_ago_ff <= 4'h5 ##1 !O_PRESET_STB; endproperty
  a_preset: assert property (p_preset) else $error("bad preset pulse");
  property p_upd_hold; O_UPD_VALID && !I_UPD_READY |=> O_UPD_VALID && $stable(O_UPD_WORD); endproperty
  a_upd_hold: assert property (p_upd_hold) else $error("update word lost");
endmodule // tap_decode_sva
bind tap_decode tap_decode_sva #(.FIFO_DEPTH(FIFO_DEPTH), .FIFO_AW(FIFO_AW)) tap_decode_sva_i (
  .I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_TCK(I_TCK), .I_TRST_B(I_TRST_B), .I_TLR(I_TLR),
  .I_UPDATE_IR(I_UPDATE_IR), .I_CPU_RESET(I_CPU_RESET), .I_UPD_READY(I_UPD_READY), .O_TDO(O_TDO),
  .O_INSTR(O_INSTR), .O_BOOT_DEBUG(O_BOOT_DEBUG), .O_PRESET_STB(O_PRESET_STB),
  .O_UPD_VALID(O_UPD_VALID), .O_UPD_WORD(O_UPD_WORD));

// File: probe_model.sv
`timescale 1ns/1ps
// ====
// Probe side: scan pins and controller state levels.
module probe_model (
  output reg       o_tck, // scan clock
  output reg       o_tdi, // serial to device
  output reg [6:0] o_st,  // tlr,cir,sir,uir,cdr,sdr,udr
  input  wire      i_tdo  // serial from device
);
  // The clock rests low between frames.
  initial begin
    o_tck = 1'b0;
    o_tdi = 1'b0;
    o_st = 7'h00;
  end
  // State and data lead the falling edge, so the device never sees a fall with a stale state.
  task pulse(input [6:0] s, input d, output q);
    begin
      o_st = s;
      o_tdi = d;
      #0.5;
      o_tck = 1'b0;
      #62.0;
      q = i_tdo;
      o_tck = 1'b1;
      #62.5;
    end
  endtask
  task scan(input ir, input integer n, input [95:0] din, output [95:0] dout);
    integer k;
    reg q;
    begin
      pulse(ir ? 7'h20 : 7'h04, 1'b0, q);
      for (k = 0; k < n; k = k + 1) begin
        pulse(ir ? 7'h10 : 7'h02, din[k], q);
        dout[k] = q;
      end
      pulse(ir ? 7'h08 : 7'h01, ~din[n-1], q);
      pulse(7'h00, din[n-1], q);
      #0.5;
      o_tck = 1'b0;
      // A released line shows the inverse, never a stale copy.
      o_tdi = ~din[n-1];
    end
  endtask
endmodule // probe_model

// File: tb.sv
`timescale 1ns/1ps
`include "tap_decode_map.vh"
// ====
// Self-checking bench.
module tb;
  localparam [69:0] CODES = {5'h15, 5'h10, 5'h02, 5'h00, 5'h0D, 5'h0C, 5'h1F, 5'h0E, 5'h0B, 5'h0A, 5'h09, 5'h08, 5'h03, 5'h01};
  reg         clk, rst_b, trst_b, cpu_reset, upd_ready, fast_cap, preset_val, b, last_extra;
  reg  [3:0]  version;
  reg  [15:0] part;
  reg  [10:0] maker;
  reg  [31:0] impl, addr_cap, data_cap, ctrl_cap, rv, last_word;
  reg  [95:0] dout, din;
  reg  [4:0]  c;
  reg  [2:0]  last_path;
  wire        tck, tdi, tdo, boot_debug, preset_stb, upd_valid, upd_ovf, upd_extra;
  wire [6:0]  st;
  wire [4:0]  instr;
  wire [2:0]  upd_path;
  wire [31:0] upd_word;
  integer     seed, num_errors, cmp_count, words, ovfs, k;
  probe_model probe_model_i (.o_tck(tck), .o_tdi(tdi), .o_st(st), .i_tdo(tdo));
  tap_decode #(.FIFO_DEPTH(16), .FIFO_AW(4)) tap_decode_i (
    .I_CLK(clk), .I_RST_B(rst_b), .I_TCK(tck), .I_TDI(tdi), .I_TRST_B(trst_b), .I_TLR(st[6]),
    .I_CAPTURE_IR(st[5]), .I_SHIFT_IR(st[4]), .I_UPDATE_IR(st[3]), .I_CAPTURE_DR(st[2]),
    .I_SHIFT_DR(st[1]), .I_UPDATE_DR(st[0]), .I_CPU_RESET(cpu_reset), .I_VERSION(version),
    .I_PART(part), .I_MAKER(maker), .I_IMPL(impl), .I_ADDR_CAP(addr_cap), .I_DATA_CAP(data_cap),
    .I_CTRL_CAP(ctrl_cap), .I_FAST_CAP(fast_cap), .I_UPD_READY(upd_ready), .O_TDO(tdo),
    .O_INSTR(instr), .O_BOOT_DEBUG(boot_debug), .O_PRESET_STB(preset_stb), .O_UPD_VALID(upd_valid),
    .O_UPD_PATH(upd_path), .O_UPD_WORD(upd_word), .O_UPD_EXTRA(upd_extra), .O_UPD_OVF(upd_ovf));
  initial clk = 1'b0;
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (upd_valid && upd_ready) begin
      words = words + 1;
      last_word = upd_word;
      last_path = upd_path;
      last_extra = upd_extra;
    end
    if (preset_stb) preset_val = boot_debug;
    if (upd_ovf) ovfs = ovfs + 1;
  end
  task chk(input [8*8-1:0] name, input [95:0] e, input [95:0] g);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("ERROR %0s expected %h seen %h", name, e, g);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  function [95:0] expect_out(input [4:0] i, input [95:0] d);
    case (i)
      `INS_IDENT: expect_out = {d[63:0], version, part, maker, `ID_FIXED_BIT};
      `INS_IMPL: expect_out = {d[63:0], impl};
      `INS_ADDR: expect_out = {d[63:0], addr_cap};
      `INS_DATA: expect_out = {d[63:0], data_cap};
      `INS_CTRL: expect_out = {d[63:0], ctrl_cap};
      `INS_ALL: expect_out = {ctrl_cap, data_cap, addr_cap};
      `INS_FAST: expect_out = {d[62:0], data_cap, fast_cap};
      default: expect_out = {d[94:0], 1'b0};
    endcase
  endfunction
  task rnd;
    begin
      @(negedge clk);
      {version, part, maker, fast_cap} = $random(seed);
      {impl, addr_cap, data_cap, ctrl_cap} = {$random(seed), $random(seed), $random(seed), $random(seed)};
    end
  endtask
  task load_ir(input [4:0] i);
    begin
      probe_model_i.scan(1'b1, 5, {91'h0, i}, dout);
      chk("ircap", 96'h1, dout & 96'h1F);
    end
  endtask
  task dr(input [4:0] i);
    begin
      din = {$random(seed), $random(seed), $random(seed)};
      probe_model_i.scan(1'b0, 96, din, dout);
      chk("scan", expect_out(i, din), dout);
      if (i == `INS_ADDR || i == `INS_DATA || i == `INS_CTRL || i == `INS_ALL || i == `INS_FAST) begin
        chk("upword", din[95:64], last_word);
        chk("uppath", i == `INS_ADDR ? `PATH_ADDR : i == `INS_DATA ? `PATH_DATA : i == `INS_CTRL ? `PATH_CTRL :
            i == `INS_ALL ? `PATH_ALL : `PATH_FAST, last_path);
        chk("upextra", i == `INS_FAST ? din[63] : 1'b0, last_extra);
      end
    end
  endtask
  task cpu_pulse(input e);
    begin
      preset_val = 1'bx;
      @(negedge clk) cpu_reset = 1'b1;
      repeat (8) @(negedge clk);
      cpu_reset = 1'b0;
      chk("preset", e, preset_val);
    end
  endtask
  initial begin
    seed = 32'hF3FFCC23;
    {num_errors, cmp_count, words, ovfs} = 0;
    {rst_b, trst_b, cpu_reset, upd_ready} = 4'h5;
    rnd;
    repeat (6) @(posedge clk);
    @(negedge clk) rst_b = 1'b1;
    dr(`INS_IDENT);
    $display("test ident done");
    for (k = 0; k < 18; k = k + 1) begin
      rv = $random(seed);
      c = (k < 14) ? CODES[k*5 +: 5] : rv[4:0];
      rnd;
      load_ir(c);
      chk("instr", c, instr);
      dr(c);
    end
    $display("test decode done");
    load_ir(`INS_DBOOT);
    load_ir(`INS_CTRL);
    chk("boot", 1'b1, boot_debug);
    cpu_pulse(1'b1);
    load_ir(`INS_NBOOT);
    cpu_pulse(1'b0);
    load_ir(`INS_DBOOT);
    probe_model_i.pulse(7'h40, 1'b0, b);
    chk("tlrboot", {1'b0, `INS_IDENT}, {boot_debug, instr});
    load_ir(`INS_DBOOT);
    @(negedge clk) trst_b = 1'b0;
    repeat (10) @(negedge clk);
    trst_b = 1'b1;
    chk("trstboot", {1'b0, `INS_IDENT}, {boot_debug, instr});
    $display("test boot done");
    load_ir(`INS_ADDR);
    @(negedge clk) upd_ready = 1'b0;
    words = 0;
    ovfs = 0;
    // Sixteen stored words and the two output registers fill up; the last two scans are dropped.
    repeat (20) probe_model_i.scan(1'b0, 1, 96'h0, dout);
    chk("ovf", 2, ovfs);
    @(negedge clk) upd_ready = 1'b1;
    repeat (40) @(negedge clk);
    chk("drain", 16 + 2, words);
    $display("test buffer done");
    print_verdict;
  end
  initial begin
    #800000;
    num_errors = num_errors + 1;
    print_verdict;
  end
endmodule // tb
